/* src/psm_pin_state_mode_control.sv */
// top of the pin state and mode control block
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - level bit set in standby: general pins float, inward value low
// - held pins keep prior state; peripheral pins follow peripheral
// - input forced to zero never passes the outside level inward
// - high impedance means output driver switched off
// - general pin setup blocked in power-on, reset-input and internal reset
// - low external reset input means reset-input state; high means not
// - input-enabled pins, like main clock input, pass their level inward
module psm_pin_state_mode_control (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic POWER_OK_I,
  input wire logic EXTERNAL_RESET_IN_I,
  input wire logic STANDBY_REQ_I,
  input wire logic WAKE_I,
  input wire logic STANDBY_PIN_LEVEL_I,
  input wire logic [psm_pkg::NPINS-1:0] PERIPH_SEL_I,
  input wire logic [psm_pkg::NPINS-1:0] PERIPH_OUT_I,
  input wire logic [psm_pkg::NPINS-1:0] PERIPH_OE_I,
  input wire logic [psm_pkg::NPINS-1:0] PORT_OUT_I,
  input wire logic [psm_pkg::NPINS-1:0] PORT_OE_I,
  input wire logic [psm_pkg::NPINS-1:0] PAD_I,
  output logic [psm_pkg::NPINS-1:0] PAD_O,
  output logic [psm_pkg::NPINS-1:0] PAD_OE_O,
  output logic [psm_pkg::NPINS-1:0] PIN_IN_O,
  input wire logic MAIN_CLK_PAD_I,
  output logic MAIN_CLK_IN_O,
  input wire logic OSC_RUNNING_I,
  input wire logic OSC_OUT_I,
  input wire logic OSC_OUT_PAD_I,
  output logic OSC_OUT_PAD_O,
  output logic OSC_OUT_PAD_OE_O,
  output logic OSC_OUT_IN_O,
  output logic [2:0] STATE_O
);
  psm_pkg::psm_state_t state, next_state;
  logic [3:0] rst_cnt, next_rst_cnt;
  logic blocked, hold, float_pins;

  // ----------------------------------------------------------------
  // device state sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    case (state)
      psm_pkg::ST_POR: begin
        if (POWER_OK_I) begin
          next_state = psm_pkg::ST_EXT_RST;
        end
      end
      psm_pkg::ST_EXT_RST: begin
        next_rst_cnt = psm_pkg::CNT_ZERO;
        if (EXTERNAL_RESET_IN_I) begin
          next_state = psm_pkg::ST_INT_RST;
        end
      end
      psm_pkg::ST_INT_RST: begin
        // internal reset is stretched a fixed time after the pin rises
        next_rst_cnt = rst_cnt + psm_pkg::CNT_ONE;
        if (rst_cnt == psm_pkg::INT_RST_LAST) begin
          next_state = psm_pkg::ST_RUN;
        end
      end
      psm_pkg::ST_RUN: begin
        if (STANDBY_REQ_I) begin
          next_state = psm_pkg::ST_STANDBY;
        end
      end
      psm_pkg::ST_STANDBY: begin
        if (WAKE_I) begin
          next_state = psm_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = psm_pkg::ST_POR;
      end
    endcase
    // power loss or low reset pin override every other state
    if (!POWER_OK_I) begin
      next_state = psm_pkg::ST_POR;
    end else if (!EXTERNAL_RESET_IN_I && state != psm_pkg::ST_POR) begin
      next_state = psm_pkg::ST_EXT_RST;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= psm_pkg::ST_POR;
      rst_cnt <= psm_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
    end
  end

  // ----------------------------------------------------------------
  // per-state pin policy
  // ----------------------------------------------------------------
  // blocking decoded from next state so pins react with the state register
  assign blocked = (next_state == psm_pkg::ST_POR) || (next_state == psm_pkg::ST_EXT_RST)
                 || (next_state == psm_pkg::ST_INT_RST);
  assign hold = (next_state == psm_pkg::ST_STANDBY);
  assign float_pins = hold && (STANDBY_PIN_LEVEL_I == psm_pkg::LEVEL_FLOAT);

  // one cell per general pin
  for (genvar g = 0; g < psm_pkg::NPINS; g++) begin : g_pin
    psm_pin_cell u_cell (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .blocked_i(blocked),
      .hold_i(hold),
      .float_i(float_pins),
      .periph_sel_i(PERIPH_SEL_I[g]),
      .periph_out_i(PERIPH_OUT_I[g]),
      .periph_oe_i(PERIPH_OE_I[g]),
      .port_out_i(PORT_OUT_I[g]),
      .port_oe_i(PORT_OE_I[g]),
      .pad_i(PAD_I[g]),
      .pad_o(PAD_O[g]),
      .pad_oe_o(PAD_OE_O[g]),
      .in_o(PIN_IN_O[g])
    );
  end

  // ----------------------------------------------------------------
  // clock pins
  // ----------------------------------------------------------------
  logic next_main_in, next_osc_pad, next_osc_oe, next_osc_in;
  always_comb begin
    next_main_in = MAIN_CLK_PAD_I;
    next_osc_pad = OSC_OUT_PAD_O;
    next_osc_oe = OSC_OUT_PAD_OE_O;
    next_osc_in = OSC_OUT_IN_O;
    if (blocked || !OSC_RUNNING_I) begin
      next_osc_pad = psm_pkg::ZERO;
      next_osc_oe = psm_pkg::ZERO;
      next_osc_in = psm_pkg::ZERO;
    end else begin
      next_osc_pad = OSC_OUT_I;
      next_osc_oe = psm_pkg::ONE;
      next_osc_in = OSC_OUT_PAD_I;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MAIN_CLK_IN_O <= psm_pkg::ZERO;
      OSC_OUT_PAD_O <= psm_pkg::ZERO;
      OSC_OUT_PAD_OE_O <= psm_pkg::ZERO;
      OSC_OUT_IN_O <= psm_pkg::ZERO;
      STATE_O <= psm_pkg::ST_POR;
    end else begin
      MAIN_CLK_IN_O <= next_main_in;
      OSC_OUT_PAD_O <= next_osc_pad;
      OSC_OUT_PAD_OE_O <= next_osc_oe;
      OSC_OUT_IN_O <= next_osc_in;
      STATE_O <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic in_stby;
  assign in_stby = (STATE_O == psm_pkg::ST_STANDBY);

  property p_float_pins;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (float_pins) |=> (PAD_OE_O == psm_pkg::PINS_ZERO) && (PIN_IN_O == psm_pkg::PINS_ZERO);
  endproperty
  a_float_pins: assert property (p_float_pins) else $error("standby float not applied");

  property p_hold_port;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (hold && !float_pins && PERIPH_SEL_I == psm_pkg::PINS_ZERO && $past(hold))
        |=> $stable(PAD_O) && $stable(PAD_OE_O);
  endproperty
  a_hold_port: assert property (p_hold_port) else $error("held port output changed");

  property p_periph_follow;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (!blocked && !float_pins && PERIPH_SEL_I[0]) |=> (PAD_O[0] == $past(PERIPH_OUT_I[0]));
  endproperty
  a_periph_follow: assert property (p_periph_follow) else $error("pin not following peripheral");

  // the level bit must already have been set on the edge that loaded the pin,
  // otherwise the first standby cycle after setting it still shows the old pad level
  property p_forced_zero;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (!PAD_OE_O[0] && in_stby && STANDBY_PIN_LEVEL_I && $past(STANDBY_PIN_LEVEL_I))
        |-> !PIN_IN_O[0];
  endproperty
  a_forced_zero: assert property (p_forced_zero) else $error("forced input leaked level");

  property p_hiz_osc;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (!OSC_RUNNING_I) |=> !OSC_OUT_PAD_OE_O;
  endproperty
  a_hiz_osc: assert property (p_hiz_osc) else $error("stopped oscillator pin still driven");

  property p_blocked;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (STATE_O != psm_pkg::ST_RUN && STATE_O != psm_pkg::ST_STANDBY) |-> (PAD_OE_O == psm_pkg::PINS_ZERO);
  endproperty
  a_blocked: assert property (p_blocked) else $error("pin driven during reset");

  sequence s_pin_low;
    POWER_OK_I && !EXTERNAL_RESET_IN_I && STATE_O != psm_pkg::ST_POR;
  endsequence
  property p_ext_rst;
    @(posedge REF_CLK_I) disable iff (RST_I)
      s_pin_low |=> (STATE_O == psm_pkg::ST_EXT_RST);
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("reset input state not entered");

  property p_main_in;
    @(posedge REF_CLK_I) disable iff (RST_I)
      1'b1 |=> (MAIN_CLK_IN_O == $past(MAIN_CLK_PAD_I));
  endproperty
  a_main_in: assert property (p_main_in) else $error("main clock input not passed");

  property p_osc_stop;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (!OSC_RUNNING_I) |=> (!OSC_OUT_IN_O && !OSC_OUT_PAD_OE_O);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator pin not floated");

  // stretch is ten cycles: first cycle, then nine more with power and pin high
  sequence s_int_start;
    $rose(STATE_O == psm_pkg::ST_INT_RST) && POWER_OK_I && EXTERNAL_RESET_IN_I;
  endsequence
  sequence s_int_stay;
    (POWER_OK_I && EXTERNAL_RESET_IN_I)[*8] ##1 (POWER_OK_I && EXTERNAL_RESET_IN_I);
  endsequence
  property p_int_len;
    @(posedge REF_CLK_I) disable iff (RST_I)
      s_int_start ##1 s_int_stay
        |-> (STATE_O == psm_pkg::ST_INT_RST) ##1 (STATE_O == psm_pkg::ST_RUN);
  endproperty
  a_int_len: assert property (p_int_len) else $error("internal reset length wrong");
endmodule
`default_nettype wire

/* src/psm_pkg.sv */
// shared constants and types for the pin state and mode control block
package psm_pkg;
  // ----------------------------------------------------------------
  // device state codes (gray along reset -> run -> standby path)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR     = 3'h0,
    ST_EXT_RST = 3'h1,
    ST_INT_RST = 3'h3,
    ST_RUN     = 3'h2,
    ST_STANDBY = 3'h6
  } psm_state_t;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NPINS = 8;
  localparam logic [NPINS-1:0] PINS_ZERO = 8'h00;
  localparam logic ZERO = 1'b0;
  localparam logic ONE = 1'b1;
  localparam logic LEVEL_FLOAT = 1'b1;  // standby level bit value that floats pins
  // internal reset stretch after the external reset input rises
  localparam int unsigned INT_RST_NS = 80;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned INT_RST_CYCLES = (INT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] INT_RST_LAST = 4'(INT_RST_CYCLES - 1);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
endpackage

/* src/psm_pin_cell.sv */
// one pin cell: drive, enable and inward path for a single general-purpose pin
`timescale 1ns/1ps
`default_nettype none
module psm_pin_cell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic blocked_i,
  input wire logic hold_i,
  input wire logic float_i,
  input wire logic periph_sel_i,
  input wire logic periph_out_i,
  input wire logic periph_oe_i,
  input wire logic port_out_i,
  input wire logic port_oe_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic in_o
);
  logic next_pad_o;
  logic next_pad_oe_o;
  logic next_in_o;

  // pick drive and inward value for this pin
  always_comb begin
    next_pad_o = pad_o;
    next_pad_oe_o = pad_oe_o;
    next_in_o = pad_i;
    if (blocked_i) begin
      next_pad_o = psm_pkg::ZERO;
      next_pad_oe_o = psm_pkg::ZERO;
      next_in_o = psm_pkg::ZERO;
    end else if (float_i) begin
      next_pad_oe_o = psm_pkg::ZERO;
      next_in_o = psm_pkg::ZERO;
    end else if (periph_sel_i) begin
      // a running peripheral keeps steering the pin even while held
      next_pad_o = periph_out_i;
      next_pad_oe_o = periph_oe_i;
    end else if (!hold_i) begin
      next_pad_o = port_out_i;
      next_pad_oe_o = port_oe_i;
    end
  end

  // register pin outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_o <= psm_pkg::ZERO;
      pad_oe_o <= psm_pkg::ZERO;
      in_o <= psm_pkg::ZERO;
    end else begin
      pad_o <= next_pad_o;
      pad_oe_o <= next_pad_oe_o;
      in_o <= next_in_o;
    end
  end
endmodule
`default_nettype wire

/* tb/psm_board.sv */
// board model for the pads: level seen on each pad given the chip's drive
`timescale 1ns/1ps
`default_nettype none
module psm_board (
  input wire logic clk_i,
  input wire logic [psm_pkg::NPINS-1:0] drive_i,
  input wire logic [psm_pkg::NPINS-1:0] drive_oe_i,
  input wire logic [psm_pkg::NPINS-1:0] board_level_i,
  input wire logic osc_drive_i,
  input wire logic osc_oe_i,
  output logic [psm_pkg::NPINS-1:0] pad_o,
  output logic osc_pad_o
);
  logic osc_last = 1'b0;
  // released pins settle to the board's own resistor level
  assign pad_o = (drive_oe_i & drive_i) | (~drive_oe_i & board_level_i);
  // no pull on the oscillator pad, so a released pad never shows a stale level
  assign osc_pad_o = osc_oe_i ? osc_drive_i : ~osc_last;
  always_ff @(posedge clk_i) begin
    osc_last <= osc_pad_o;
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the pin state and mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwr = 1'b0;
  logic xrst = 1'b0;
  logic req = 1'b0;
  logic wake = 1'b0;
  logic lvl = 1'b0;
  logic mclk = 1'b0;
  logic orun = 1'b1;
  logic oout = 1'b0;
  logic mc, mr, oc, oc_d, orn, oen;
  logic oen_d = 1'b0;
  logic [7:0] sel = 8'h00, pout = 8'h00, poe = 8'h00, qout = 8'h00, qoe = 8'h00;
  logic [7:0] ext = 8'hFF, a_out, a_oe;
  wire logic [7:0] pad_i, pad_o, pad_oe, pin_in;
  wire logic mclk_in, opad_i, opad_o, ooe, oin;
  wire logic [2:0] state;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  psm_pin_state_mode_control dut (
    .REF_CLK_I(clk), .RST_I(rst), .POWER_OK_I(pwr), .EXTERNAL_RESET_IN_I(xrst),
    .STANDBY_REQ_I(req), .WAKE_I(wake), .STANDBY_PIN_LEVEL_I(lvl),
    .PERIPH_SEL_I(sel), .PERIPH_OUT_I(pout), .PERIPH_OE_I(poe),
    .PORT_OUT_I(qout), .PORT_OE_I(qoe), .PAD_I(pad_i),
    .PAD_O(pad_o), .PAD_OE_O(pad_oe), .PIN_IN_O(pin_in),
    .MAIN_CLK_PAD_I(mclk), .MAIN_CLK_IN_O(mclk_in),
    .OSC_RUNNING_I(orun), .OSC_OUT_I(oout), .OSC_OUT_PAD_I(opad_i),
    .OSC_OUT_PAD_O(opad_o), .OSC_OUT_PAD_OE_O(ooe), .OSC_OUT_IN_O(oin), .STATE_O(state)
  );
  psm_board board (
    .clk_i(clk), .drive_i(pad_o), .drive_oe_i(pad_oe), .board_level_i(ext),
    .osc_drive_i(opad_o), .osc_oe_i(ooe), .pad_o(pad_i), .osc_pad_o(opad_i)
  );

  always #4 clk = ~clk;

  // hang guard: the whole sequence needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  // main clock pad wiggles every cycle and must come through one edge later;
  // a running oscillator drives its pad and reads it back one edge after that
  always @(posedge clk) begin
    mc = mclk;
    mr = rst;
    oc_d = oc;
    oc = oout;
    orn = orun;
    #1;
    mclk = 1'($urandom);
    oout = 1'($urandom);
    if (!mr) begin
      chk_bit("main_clk_in", mc, mclk_in);
      oen = orn && (state == 3'h2 || state == 3'h6);
      if (oen) begin
        chk_bit("osc_oe", 1'b1, ooe);
        chk_bit("osc_pad_o", oc, opad_o);
      end
      if (oen && oen_d) begin
        chk_bit("osc_in", oc_d, oin);
      end
      oen_d = oen;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [7:0] mux(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b);
    return (s & a) | (~s & b);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // general and oscillator pin setup must look switched off while any reset holds
  task automatic blocked();
    chk_vec("pad_oe", 8'h00, pad_oe);
    chk_vec("pin_in", 8'h00, pin_in);
    chk_bit("osc_oe", 1'b0, ooe);
    chk_bit("osc_in", 1'b0, oin);
  endtask

  // peripheral pins follow the peripheral, port pins show po and pe
  task automatic pins(input logic [7:0] po, input logic [7:0] pe);
    logic [7:0] eo;
    logic [7:0] ev;
    eo = mux(sel, poe, pe);
    ev = mux(sel, pout, po);
    chk_vec("pad_oe", eo, pad_oe);
    chk_vec("pad_o", ev & eo, pad_o & eo);
    chk_vec("pin_in", mux(eo, ev, ext), pin_in);
  endtask

  // release the reset pin and time the internal reset stretch
  task automatic boot();
    int n;
    n = 0;
    xrst = 1'b1;
    tick(1);
    while (state === 3'h3 && n < 40) begin
      blocked();
      n++;
      tick(1);
    end
    chk_vec("int_rst_len", 8'(psm_pkg::INT_RST_CYCLES), 8'(n));
    chk_vec("state", 8'h02, 8'(state));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hD70648CF));
    tick(3);
    rst = 1'b0;
    tick(2);
    chk_vec("state", 8'h00, 8'(state));
    blocked();
    pwr = 1'b1;
    tick(2);
    chk_vec("state", 8'h01, 8'(state));
    blocked();
    boot();
    // run mode, first two passes are all-port and all-peripheral corners
    for (int i = 0; i < 12; i++) begin
      sel = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      pout = 8'($urandom);
      poe = (i == 1) ? 8'hFF : 8'($urandom);
      qout = 8'($urandom);
      qoe = (i == 0) ? 8'hFF : 8'($urandom);
      ext = 8'($urandom);
      tick(3);
      pins(qout, qoe);
    end
    // standby with level bit clear: port values freeze
    a_out = qout;
    a_oe = qoe;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    chk_vec("state", 8'h06, 8'(state));
    qout = ~qout;
    qoe = ~qoe;
    pout = ~pout;
    poe = ~poe;
    tick(3);
    pins(a_out, a_oe);
    // level bit set: general pins float and read low
    lvl = 1'b1;
    sel = 8'h00;
    ext = 8'hFF;
    tick(3);
    chk_vec("pad_oe", 8'h00, pad_oe);
    chk_vec("pin_in", 8'h00, pin_in);
    lvl = 1'b0;
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    chk_vec("state", 8'h02, 8'(state));
    orun = 1'b0;
    tick(3);
    chk_bit("osc_oe", 1'b0, ooe);
    chk_bit("osc_in", 1'b0, oin);
    orun = 1'b1;
    // second standby with no peripheral pins: every port pin freezes
    a_out = qout;
    a_oe = qoe;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    chk_vec("state", 8'h06, 8'(state));
    qout = ~qout;
    qoe = ~qoe;
    tick(2);
    pins(a_out, a_oe);
    // reset pin pulled low in mid standby, then power loss
    xrst = 1'b0;
    tick(2);
    chk_vec("state", 8'h01, 8'(state));
    blocked();
    boot();
    pwr = 1'b0;
    tick(2);
    chk_vec("state", 8'h00, 8'(state));
    blocked();
    end_sim();
  end
endmodule
`default_nettype wire
